/* File: inc/tco_pkg.sv */
// shared constants for the sixteen-bit timer/counter one block
package tco_pkg;
    // bus geometry
    localparam int AXI_AW = 8;
    localparam int AXI_DW = 32;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // register byte offsets
    localparam logic [7:0] OFF_CONTROL = 8'h00;
    localparam logic [7:0] OFF_COUNT_LOW = 8'h04;
    localparam logic [7:0] OFF_COUNT_HIGH = 8'h08;
    localparam logic [7:0] OFF_FLAGS_ONE = 8'h0c;
    localparam logic [7:0] OFF_IRQ_ENABLE = 8'h10;

    // register select indices (one-hot positions)
    localparam int SEL_CONTROL = 0;
    localparam int SEL_COUNT_LOW = 1;
    localparam int SEL_COUNT_HIGH = 2;
    localparam int SEL_FLAGS_ONE = 3;
    localparam int SEL_IRQ_ENABLE = 4;
    localparam int SEL_W = 5;

    // counter_one_control fields
    localparam int BIT_COUNTER_RUN = 0;
    localparam int BIT_COUNT_SOURCE = 1;
    localparam int BIT_SYNC_DISABLE = 2;
    localparam int BIT_CRYSTAL_OSC_EN = 3;
    localparam int BIT_DIV_LO = 4;
    localparam int BIT_DIV_HI = 5;
    localparam int BIT_WIDE_ACCESS = 7;
    localparam logic [7:0] CONTROL_WMASK = 8'hbf;
    localparam logic [7:0] CONTROL_RESET = 8'h00;

    // peripheral_flags_one / enable fields
    localparam int BIT_WRAP_FLAG = 0;
    localparam int BIT_WRAP_IRQ_EN = 0;

    // count reset values and wrap point
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] COUNT_MAX = 16'hffff;
    localparam logic [7:0] BUF_RESET = 8'h00;

    // instruction clock is the core clock divided by four
    localparam logic [1:0] INSTR_DIV_LAST = 2'h3;

    // input divider codes
    localparam logic [1:0] DIV_1 = 2'b00;
    localparam logic [1:0] DIV_2 = 2'b01;
    localparam logic [1:0] DIV_4 = 2'b10;
    localparam logic [1:0] DIV_8 = 2'b11;
endpackage

/* File: hdl/tco_edge_sync.sv */
// two-flop synchroniser with rising edge detect for a count pin
`timescale 1ns/1ps
module tco_edge_sync (
    input wire logic i_clk_sys,
    input wire logic i_nrst,
    input wire logic i_pin,
    output logic o_rise
);
    logic meta_q;
    logic sync_q;
    logic prev_q;

    // meta_q feeds sync_q only
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
        end else begin
            meta_q <= i_pin;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign o_rise = sync_q & ~prev_q;
endmodule

/* File: hdl/tco_prescaler.sv */
// input divider: passes one of every 1, 2, 4 or 8 ticks
`timescale 1ns/1ps
module tco_prescaler
    import tco_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_nrst,
    input wire logic i_clear,
    input wire logic i_tick,
    input wire logic [1:0] i_sel,
    output logic o_tick
);
    logic [2:0] cnt_q;
    logic [2:0] cnt_d;
    logic [2:0] last;

    assign last = (i_sel == DIV_8) ? 3'h7 :
                  (i_sel == DIV_4) ? 3'h3 :
                  (i_sel == DIV_2) ? 3'h1 : 3'h0;
    assign o_tick = i_tick & (cnt_q >= last);
    assign cnt_d = i_clear ? 3'h0 : o_tick ? 3'h0 : i_tick ? cnt_q + 3'h1 : cnt_q;

    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            cnt_q <= 3'h0;
        end else begin
            cnt_q <= cnt_d;
        end
    end
endmodule

/* File: hdl/tco_timer_one.sv */
// sixteen-bit timer/counter one with axi4-lite register access
//
// Chosen here: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module tco_timer_one
    import tco_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_nrst,
    // axi4-lite slave
    input wire logic [AXI_AW-1:0] i_s_axi_awaddr,
    input wire logic i_s_axi_awvalid,
    output logic o_s_axi_awready,
    input wire logic [AXI_DW-1:0] i_s_axi_wdata,
    input wire logic [3:0] i_s_axi_wstrb,
    input wire logic i_s_axi_wvalid,
    output logic o_s_axi_wready,
    output logic [1:0] o_s_axi_bresp,
    output logic o_s_axi_bvalid,
    input wire logic i_s_axi_bready,
    input wire logic [AXI_AW-1:0] i_s_axi_araddr,
    input wire logic i_s_axi_arvalid,
    output logic o_s_axi_arready,
    output logic [AXI_DW-1:0] o_s_axi_rdata,
    output logic [1:0] o_s_axi_rresp,
    output logic o_s_axi_rvalid,
    input wire logic i_s_axi_rready,
    // count inputs and system hooks
    input wire logic i_external_count_pin,
    input wire logic i_crystal_in_pin,
    input wire logic i_special_event,
    input wire logic i_core_sleep,
    output logic o_crystal_osc_enable,
    output logic o_osc_pins_override,
    output logic [15:0] o_count,
    output logic o_wrap_irq
);
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [SEL_W-1:0] reg_sel(input logic [AXI_AW-1:0] a);
        logic [AXI_AW-1:0] w;
        w = {a[AXI_AW-1:2], 2'b00};
        reg_sel = '0;
        if (w == OFF_CONTROL) begin
            reg_sel[SEL_CONTROL] = 1'b1;
        end else if (w == OFF_COUNT_LOW) begin
            reg_sel[SEL_COUNT_LOW] = 1'b1;
        end else if (w == OFF_COUNT_HIGH) begin
            reg_sel[SEL_COUNT_HIGH] = 1'b1;
        end else if (w == OFF_FLAGS_ONE) begin
            reg_sel[SEL_FLAGS_ONE] = 1'b1;
        end else if (w == OFF_IRQ_ENABLE) begin
            reg_sel[SEL_IRQ_ENABLE] = 1'b1;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // state
    logic aw_full_q, w_full_q, bvalid_q, awready_q, wready_q;
    logic [1:0] bresp_q;
    logic arready_q, rvalid_q;
    logic [1:0] rresp_q;
    logic [AXI_DW-1:0] rdata_q;
    logic [AXI_AW-1:0] aw_addr_q;
    logic [7:0] w_data_q;
    logic w_strb_q;
    logic [7:0] ctrl_q;
    logic [15:0] count_q;
    logic [15:0] count_d;
    logic [7:0] hbuf_q;
    logic wrap_flag_q, wrap_flag_d;
    logic irq_en_q;
    logic irq_q;
    logic [1:0] instr_cnt_q;

    ////////////////////////////////////////////////////////////////////////////
    // write channel: address and data may arrive in either order
    wire aw_hs = i_s_axi_awvalid & awready_q;
    wire w_hs = i_s_axi_wvalid & wready_q;
    wire do_wr = aw_full_q & w_full_q & ~bvalid_q;
    wire aw_full_d = (aw_full_q | aw_hs) & ~do_wr;
    wire w_full_d = (w_full_q | w_hs) & ~do_wr;
    wire bvalid_d = (bvalid_q & ~i_s_axi_bready) | do_wr;
    wire [SEL_W-1:0] wsel = reg_sel(aw_addr_q);
    wire wr_en = do_wr & w_strb_q; // only lane 0 carries register bits
    wire wr_ctrl = wr_en & wsel[SEL_CONTROL];
    wire wr_low = wr_en & wsel[SEL_COUNT_LOW];
    wire wr_high = wr_en & wsel[SEL_COUNT_HIGH];
    wire wr_flags = wr_en & wsel[SEL_FLAGS_ONE];
    wire wr_irqen = wr_en & wsel[SEL_IRQ_ENABLE];

    // read channel
    wire ar_hs = i_s_axi_arvalid & arready_q;
    wire [SEL_W-1:0] rsel = reg_sel(i_s_axi_araddr);
    wire wide = ctrl_q[BIT_WIDE_ACCESS];
    wire rd_low_wide = ar_hs & rsel[SEL_COUNT_LOW] & wide;
    wire [7:0] high_view = wide ? hbuf_q : count_q[15:8];
    wire [7:0] rbyte = rsel[SEL_CONTROL] ? ctrl_q :
                       rsel[SEL_COUNT_LOW] ? count_q[7:0] :
                       rsel[SEL_COUNT_HIGH] ? high_view :
                       rsel[SEL_FLAGS_ONE] ? {7'h00, wrap_flag_q} :
                       rsel[SEL_IRQ_ENABLE] ? {7'h00, irq_en_q} : 8'h00;
    wire rd_hit = |rsel;

    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            bvalid_q <= 1'b0;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            bresp_q <= RESP_OKAY;
            aw_addr_q <= '0;
            w_data_q <= 8'h00;
            w_strb_q <= 1'b0;
        end else begin
            aw_full_q <= aw_full_d;
            w_full_q <= w_full_d;
            bvalid_q <= bvalid_d;
            awready_q <= ~aw_full_d & ~bvalid_d;
            wready_q <= ~w_full_d & ~bvalid_d;
            if (aw_hs) begin
                aw_addr_q <= i_s_axi_awaddr;
            end
            if (w_hs) begin
                w_data_q <= i_s_axi_wdata[7:0];
                w_strb_q <= i_s_axi_wstrb[0];
            end
            if (do_wr) begin
                bresp_q <= (|wsel) ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rresp_q <= RESP_OKAY;
            rdata_q <= '0;
        end else if (ar_hs) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            rdata_q <= {24'h000000, rbyte};
        end else if (rvalid_q) begin
            rvalid_q <= ~i_s_axi_rready;
            arready_q <= i_s_axi_rready;
        end else begin
            arready_q <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // count sources
    wire run = ctrl_q[BIT_COUNTER_RUN];
    wire ext_src = ctrl_q[BIT_COUNT_SOURCE];
    wire no_sync = ctrl_q[BIT_SYNC_DISABLE];
    wire osc_en = ctrl_q[BIT_CRYSTAL_OSC_EN];
    wire instr_tick = (instr_cnt_q == INSTR_DIV_LAST);
    logic pin_rise;
    logic xtal_rise;
    logic cnt_tick;

    // async mode still samples through the flops; no edge is finer than 4 ns
    // one synchroniser per pin, so the source mux never sits ahead of the flops
    tco_edge_sync u_edge_pin (
        .i_clk_sys(i_clk_sys),
        .i_nrst(i_nrst),
        .i_pin(i_external_count_pin),
        .o_rise(pin_rise)
    );

    tco_edge_sync u_edge_xtal (
        .i_clk_sys(i_clk_sys),
        .i_nrst(i_nrst),
        .i_pin(i_crystal_in_pin),
        .o_rise(xtal_rise)
    );
    wire ext_rise = osc_en ? xtal_rise : pin_rise;

    // sync mode and timer mode stall in sleep, async mode keeps counting
    wire ext_ok = ext_rise & (no_sync | ~i_core_sleep);
    wire int_ok = instr_tick & ~i_core_sleep;
    wire pre_in = run & (ext_src ? ext_ok : int_ok);

    tco_prescaler u_pre (
        .i_clk_sys(i_clk_sys),
        .i_nrst(i_nrst),
        .i_clear(wr_low),
        .i_tick(pre_in),
        .i_sel(ctrl_q[BIT_DIV_HI:BIT_DIV_LO]),
        .o_tick(cnt_tick)
    );

    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            instr_cnt_q <= 2'h0;
        end else begin
            instr_cnt_q <= instr_cnt_q + 2'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // count, buffer and flag
    wire wr_high_live = wr_high & ~wide;
    wire cnt_wr = wr_low | wr_high_live;
    wire wrap_set = cnt_tick & (count_q == COUNT_MAX) & ~cnt_wr & ~i_special_event;

    assign count_d = wr_low ? {high_view, w_data_q} :
                     wr_high_live ? {w_data_q, count_q[7:0]} :
                     i_special_event ? COUNT_RESET :
                     cnt_tick ? count_q + 16'h0001 : count_q;
    // hardware set beats a software clear in the same cycle
    assign wrap_flag_d = wrap_set | (wr_flags ? w_data_q[BIT_WRAP_FLAG] : wrap_flag_q);

    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            ctrl_q <= CONTROL_RESET;
            count_q <= COUNT_RESET;
            hbuf_q <= BUF_RESET;
            wrap_flag_q <= 1'b0;
            irq_en_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= w_data_q & CONTROL_WMASK;
            end
            count_q <= count_d;
            // a buffer write beats a same-cycle latch from a low read
            if (wr_high & wide) begin
                hbuf_q <= w_data_q;
            end else if (rd_low_wide) begin
                hbuf_q <= count_q[15:8];
            end
            wrap_flag_q <= wrap_flag_d;
            if (wr_irqen) begin
                irq_en_q <= w_data_q[BIT_WRAP_IRQ_EN];
            end
            irq_q <= wrap_flag_d & (wr_irqen ? w_data_q[BIT_WRAP_IRQ_EN] : irq_en_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs
    assign o_s_axi_awready = awready_q;
    assign o_s_axi_wready = wready_q;
    assign o_s_axi_bvalid = bvalid_q;
    assign o_s_axi_bresp = bresp_q;
    assign o_s_axi_arready = arready_q;
    assign o_s_axi_rvalid = rvalid_q;
    assign o_s_axi_rresp = rresp_q;
    assign o_s_axi_rdata = rdata_q;
    // software must allow start-up time before trusting crystal counts
    assign o_crystal_osc_enable = ctrl_q[BIT_CRYSTAL_OSC_EN];
    assign o_osc_pins_override = ctrl_q[BIT_CRYSTAL_OSC_EN];
    assign o_count = count_q;
    assign o_wrap_irq = irq_q;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    a_wrap_sets_flag: assert property (
        @(posedge i_clk_sys) disable iff (!i_nrst)
        wrap_set |=> (wrap_flag_q && count_q == COUNT_RESET))
        else $error("wrap did not set flag and zero count");

    a_event_clears: assert property (
        @(posedge i_clk_sys) disable iff (!i_nrst)
        (i_special_event && !cnt_wr) |=> count_q == COUNT_RESET)
        else $error("special event did not clear count");

    a_event_no_flag: assert property (
        @(posedge i_clk_sys) disable iff (!i_nrst)
        (i_special_event && !wrap_flag_q && !wr_flags) |=> !wrap_flag_q)
        else $error("special event set the wrap flag");

    a_write_beats_event: assert property (
        @(posedge i_clk_sys) disable iff (!i_nrst)
        (wr_low && i_special_event) |=> count_q[7:0] == $past(w_data_q))
        else $error("special event beat a low byte write");

    a_stopped_holds: assert property (
        @(posedge i_clk_sys) disable iff (!i_nrst)
        (!run && !cnt_wr && !i_special_event) |=> count_q == $past(count_q))
        else $error("stopped counter moved");

    a_low_read_latch: assert property (
        @(posedge i_clk_sys) disable iff (!i_nrst)
        (rd_low_wide && !wr_high) |=> hbuf_q == $past(count_q[15:8]))
        else $error("low read did not latch high byte");

    a_wide_low_write: assert property (
        @(posedge i_clk_sys) disable iff (!i_nrst)
        (wr_low && wide) |=> count_q[15:8] == $past(hbuf_q))
        else $error("high byte not loaded from buffer");

    a_timer_rate: assert property (
        @(posedge i_clk_sys) disable iff (!i_nrst)
        (run && !ext_src && ctrl_q[BIT_DIV_HI:BIT_DIV_LO] == DIV_1 && !i_core_sleep && instr_tick
         && !cnt_wr && !i_special_event && !wr_ctrl) |=> count_q == $past(count_q) + 16'h0001)
        else $error("timer mode missed an instruction cycle");

    a_unused_bit: assert property (
        @(posedge i_clk_sys) disable iff (!i_nrst)
        wr_ctrl |=> !ctrl_q[6])
        else $error("unimplemented control bit stored");
endmodule

/* File: dv/tco_ext_src.sv */
// far-side model: external count pin and low-frequency crystal
`timescale 1ns/1ps
module tco_ext_src (
    input wire logic i_clk_sys,
    input wire logic i_osc_en,
    input wire logic i_pin_run,
    input wire logic i_xtal_hold,
    output logic o_pin,
    output logic o_xtal,
    output logic [15:0] o_pin_rises,
    output logic [15:0] o_xtal_rises
);
    int pin_div;
    int xtal_div;
    int start;
    initial begin
        o_pin = 1'b0;
        o_xtal = 1'b0;
        o_pin_rises = 16'h0000;
        o_xtal_rises = 16'h0000;
        pin_div = 0;
        xtal_div = 0;
        start = 0;
    end
    ////////////////////////////////////////////////////////////////
    // pin clock stands still at its last level when not running
    always @(posedge i_clk_sys) begin
        pin_div <= (pin_div == 4) ? 0 : pin_div + 1;
        if (i_pin_run && pin_div == 4) begin
            o_pin <= ~o_pin;
            if (!o_pin) begin
                o_pin_rises <= o_pin_rises + 16'h0001; // rising edges are the counted ones
            end
        end
    end
    ////////////////////////////////////////////////////////////////
    // crystal: silent while shut off, slow to start, deaf to sleep
    always @(posedge i_clk_sys) begin
        if (!i_osc_en) begin
            start <= 0; // shut off, no output
            o_xtal <= 1'b0;
        end else if (start < 12) begin
            start <= start + 1; // no edges before start-up ends
        end else if (!i_xtal_hold) begin // sleep has no input here
            xtal_div <= (xtal_div == 6) ? 0 : xtal_div + 1;
            if (xtal_div == 6) begin
                o_xtal <= ~o_xtal;
                if (!o_xtal) begin
                    o_xtal_rises <= o_xtal_rises + 16'h0001;
                end
            end
        end
    end
endmodule

/* File: dv/tb.sv */
// self-checking bench for timer/counter one
`timescale 1ns/1ps
module tb
    import tco_pkg::*;
();
    typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] e; logic [1:0] r;} tco_row_t;
    logic clk = 1'b0, nrst = 1'b0, awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
    logic pin_run = 1'b0, xhold = 1'b0, sev = 1'b0, slp = 1'b0;
    logic [7:0] awa = 8'h00, ara = 8'h00;
    logic [31:0] wd = 32'h0;
    logic [3:0] wst = 4'h1;
    logic awrdy, wrdy, bv, ardy, rv, osc_en, ovr, irq, pin, xtal;
    logic [1:0] br, rr, r;
    logic [31:0] rd, d;
    logic [15:0] cnt, prise, xrise, b;
    int error_cnt = 0, comparisons = 0, g;
    logic [7:0] offs[5] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10};
    tco_row_t rows[6] = '{'{8'h08, 8'h12, 8'h12, RESP_OKAY}, '{8'h04, 8'h34, 8'h34, RESP_OKAY},
        '{8'h10, 8'h01, 8'h01, RESP_OKAY}, '{8'h14, 8'h77, 8'h00, RESP_SLVERR},
        '{8'h00, 8'hff, 8'hbf, RESP_OKAY}, '{8'h00, 8'h00, 8'h00, RESP_OKAY}};
    always #2 clk = ~clk;
    tco_timer_one dut_u (.i_clk_sys(clk), .i_nrst(nrst),
        .i_s_axi_awaddr(awa), .i_s_axi_awvalid(awv), .o_s_axi_awready(awrdy),
        .i_s_axi_wdata(wd), .i_s_axi_wstrb(wst), .i_s_axi_wvalid(wv), .o_s_axi_wready(wrdy),
        .o_s_axi_bresp(br), .o_s_axi_bvalid(bv), .i_s_axi_bready(bry),
        .i_s_axi_araddr(ara), .i_s_axi_arvalid(arv), .o_s_axi_arready(ardy),
        .o_s_axi_rdata(rd), .o_s_axi_rresp(rr), .o_s_axi_rvalid(rv), .i_s_axi_rready(rry),
        .i_external_count_pin(pin), .i_crystal_in_pin(xtal), .i_special_event(sev),
        .i_core_sleep(slp), .o_crystal_osc_enable(osc_en), .o_osc_pins_override(ovr),
        .o_count(cnt), .o_wrap_irq(irq));
    tco_ext_src src_u (.i_clk_sys(clk), .i_osc_en(osc_en), .i_pin_run(pin_run), .i_xtal_hold(xhold),
        .o_pin(pin), .o_xtal(xtal), .o_pin_rises(prise), .o_xtal_rises(xrise));
    ////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        comparisons++;
        if (s !== e) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic final_report();
        $display("counts: %0d compared, %0d mismatched", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic tmo();
        chk("wait", 32'h1, 32'h0);
        final_report();
    endtask
    // no fixed latency assumed: every wait ends on the handshake or the bound
    task automatic axw(input logic [7:0] a, input logic [7:0] v, output logic [1:0] resp);
        int n;
        n = 0;
        @(posedge clk);
        awa <= a;
        wd <= {24'h0, v};
        awv <= 1'b1;
        wv <= 1'b1;
        bry <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (n > 60) tmo();
            if (awv && awrdy) awv <= 1'b0;
            if (wv && wrdy) wv <= 1'b0;
        end while (!(bv && bry));
        resp = br;
        bry <= 1'b0;
    endtask
    task automatic axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
        int n;
        n = 0;
        @(posedge clk);
        ara <= a;
        arv <= 1'b1;
        rry <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (n > 60) tmo();
            if (arv && ardy) arv <= 1'b0;
        end while (!(rv && rry));
        v = rd;
        resp = rr;
        rry <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        logic [1:0] resp;
        axw(a, v, resp);
        chk("bresp", 32'(RESP_OKAY), {30'h0, resp});
        repeat (2) @(posedge clk);
    endtask
    task automatic rdc(input string n, input logic [7:0] a, input logic [7:0] e);
        logic [31:0] v;
        logic [1:0] resp;
        axr(a, v, resp);
        chk(n, {24'h0, e}, v);
        chk("rresp", 32'(RESP_OKAY), {30'h0, resp});
    endtask
    // cycles until the count moves; sampled before the edge's own updates
    task automatic wchg(output int n);
        logic [15:0] p;
        p = cnt;
        n = 0;
        do begin
            @(posedge clk);
            n++;
            if (n > 300) tmo();
        end while (cnt === p);
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        foreach (rows[i]) begin
            axw(rows[i].a, rows[i].d, r);
            chk("bresp", {30'h0, rows[i].r}, {30'h0, r});
            axr(rows[i].a, d, r);
            chk("rdata", {24'h0, rows[i].e}, d);
            chk("rresp", {30'h0, rows[i].r}, {30'h0, r});
        end
        $display("test registers done");
        // sync bit toggled too: the internal source must ignore it
        for (int c = 0; c < 4; c++) begin
            wr(OFF_CONTROL, {2'b00, c[1:0], 1'b0, c[0], 2'b01});
            wchg(g);
            wchg(g);
            wchg(g);
            chk("tick gap", 4 << c, g);
        end
        slp <= 1'b1;
        @(posedge clk);
        b = cnt;
        repeat (40) @(posedge clk);
        chk("timer in sleep", {16'h0, b}, {16'h0, cnt});
        slp <= 1'b0;
        $display("test divider done");
        wr(OFF_CONTROL, 8'h00);
        wr(OFF_COUNT_HIGH, 8'h00);
        wr(OFF_COUNT_LOW, 8'h55);
        repeat (40) @(posedge clk);
        chk("held count", 32'h55, {16'h0, cnt});
        @(posedge clk);
        sev <= 1'b1;
        @(posedge clk);
        sev <= 1'b0;
        #1;
        chk("cleared count", 32'h0, {16'h0, cnt});
        rdc("flag after clear", OFF_FLAGS_ONE, 8'h00);
        sev <= 1'b1;
        axw(OFF_COUNT_LOW, 8'h66, r);
        chk("write beats event", 32'h66, {16'h0, cnt});
        sev <= 1'b0;
        $display("test stop and clear done");
        wr(OFF_COUNT_HIGH, 8'hff);
        wr(OFF_COUNT_LOW, 8'hfd);
        wr(OFF_CONTROL, 8'h01);
        g = 0;
        while (cnt !== 16'h0000) begin
            @(posedge clk);
            g++;
            if (g > 100) tmo();
        end
        chk("irq at wrap", 32'h1, {31'h0, irq});
        rdc("wrap flag", OFF_FLAGS_ONE, 8'h01);
        wr(OFF_IRQ_ENABLE, 8'h00);
        chk("masked irq", 32'h0, {31'h0, irq});
        wr(OFF_FLAGS_ONE, 8'h00);
        rdc("flag cleared", OFF_FLAGS_ONE, 8'h00);
        $display("test wrap done");
        wr(OFF_CONTROL, 8'h00);
        wr(OFF_COUNT_HIGH, 8'h00);
        wr(OFF_COUNT_LOW, 8'h00);
        wr(OFF_CONTROL, 8'h80);
        wr(OFF_COUNT_HIGH, 8'h5a);
        chk("buffered high", 32'h0, {16'h0, cnt});
        wr(OFF_COUNT_LOW, 8'h11);
        chk("loaded pair", 32'h5a11, {16'h0, cnt});
        wst <= 4'h0;
        wr(OFF_COUNT_LOW, 8'h99);
        wst <= 4'h1;
        chk("strobe off", 32'h5a11, {16'h0, cnt});
        wr(OFF_COUNT_HIGH, 8'h77);
        rdc("wide low", OFF_COUNT_LOW, 8'h11);
        rdc("wide high", OFF_COUNT_HIGH, 8'h5a);
        $display("test wide access done");
        wr(OFF_CONTROL, 8'h00);
        wr(OFF_COUNT_HIGH, 8'h00);
        wr(OFF_COUNT_LOW, 8'h00);
        wr(OFF_CONTROL, 8'h03);
        b = prise;
        pin_run <= 1'b1;
        repeat (120) @(posedge clk);
        pin_run <= 1'b0;
        repeat (12) @(posedge clk);
        chk("synced count", {16'h0, prise - b}, {16'h0, cnt});
        xhold <= 1'b1;
        wr(OFF_CONTROL, 8'h0e);
        chk("osc enable", 32'h1, {31'h0, osc_en});
        chk("pin override", 32'h1, {31'h0, ovr});
        repeat (40) @(posedge clk); // start-up wait before trusting counts
        wr(OFF_COUNT_LOW, 8'h00);
        wr(OFF_CONTROL, 8'h0f);
        b = xrise;
        slp <= 1'b1;
        pin_run <= 1'b1;
        xhold <= 1'b0;
        repeat (150) @(posedge clk);
        xhold <= 1'b1;
        pin_run <= 1'b0;
        repeat (12) @(posedge clk);
        chk("crystal in sleep", {16'h0, xrise - b}, {16'h0, cnt});
        slp <= 1'b0;
        wr(OFF_CONTROL, 8'h00);
        chk("osc shut off", 32'h0, {31'h0, osc_en});
        chk("pin override off", 32'h0, {31'h0, ovr});
        $display("test external sources done");
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        chk("count after reset", 32'h0, {16'h0, cnt});
        foreach (offs[i]) begin
            rdc("reset value", offs[i], 8'h00);
        end
        $display("test reset done");
        final_report();
    end
endmodule
